/* File: core/flow_ctl_consts.vh */
// constants for the user message and native flow control block
`ifndef FLOW_CTL_CONSTS_VH
`define FLOW_CTL_CONSTS_VH

// build direction
`define BUILD_FULL_DUPLEX   2'h0
`define BUILD_SIMPLEX_TX    2'h1
`define BUILD_SIMPLEX_RX    2'h2

// wishbone register byte offsets
`define REG_CONTROL_ADDR    8'h00
`define REG_STATUS_ADDR     8'h04
`define REG_PAUSE_ADDR      8'h08

// control register fields and reset value
`define CTRL_STREAMING_BIT  0
`define CTRL_COMPLETION_BIT 1
`define CTRL_RESET          2'h0

// status register fields
`define STAT_STOP_BIT       0
`define STAT_PAUSE_BIT      1
`define STAT_MSG_BUSY_BIT   2
`define STAT_COMPL_EFF_BIT  3

// channel block kinds
`define KIND_IDLE           3'h0
`define KIND_DATA           3'h1
`define KIND_MSG_START      3'h2
`define KIND_MSG_DATA       3'h3
`define KIND_NFC            3'h4
`define KIND_CLK_COMP       3'h5
`define KIND_CH_BOND        3'h6

// native flow control word fields, ascending bit order
`define NFC_STOP_BIT        7
`define NFC_PAUSE_MSB       8
`define NFC_PAUSE_LSB       15

// user message sizing and pause count steps
`define BUS_BYTES           9'h008
`define BUS_BYTES_FULL      4'h8
`define MSG_SIZE_ONE        9'h001
`define PAUSE_STEP          9'h001
`define PAUSE_ZERO          9'h000

`endif

/* File: core/user_msg_rx_deframer.v */
// receive side of the user message path: channel blocks to a framed stream
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctl_consts.vh"

module user_msg_rx_deframer (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire        enable,
  input  wire [2:0]  chan_rx_kind,
  input  wire [0:63] chan_rx_data,
  input  wire [7:0]  chan_rx_size,
  output reg  [0:63] user_msg_rx_data,
  output reg         user_msg_rx_valid,
  output reg         user_msg_rx_last,
  output reg  [0:7]  user_msg_rx_keep
);

  reg  [8:0] msg_remain;
  reg  [8:0] cur_remain;
  wire       is_start;
  wire       is_word;
  wire       is_last;

  // leftmost n byte lanes set
  function [0:7] keep_mask;
    input [8:0] n;
    integer i;
    begin
      keep_mask = 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        keep_mask[i] = (n > i);
      end
    end
  endfunction

  assign is_start = (chan_rx_kind == `KIND_MSG_START);
  assign is_word  = enable & (is_start | (chan_rx_kind == `KIND_MSG_DATA));
  assign is_last  = (cur_remain <= `BUS_BYTES);

  always @* begin
    if (is_start) begin
      cur_remain = {1'b0, chan_rx_size} + `MSG_SIZE_ONE;
    end else begin
      cur_remain = msg_remain;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      msg_remain        <= 9'h000;
      user_msg_rx_data  <= 64'h0000_0000_0000_0000;
      user_msg_rx_valid <= 1'b0;
      user_msg_rx_last  <= 1'b0;
      user_msg_rx_keep  <= 8'h00;
    end else begin
      user_msg_rx_valid <= is_word;
      user_msg_rx_data  <= chan_rx_data;
      user_msg_rx_last  <= is_word & is_last;
      // keep only carries meaning with last; zero elsewhere
      user_msg_rx_keep  <= (is_word & is_last) ? keep_mask(cur_remain) : 8'h00;
      if (is_word) begin
        msg_remain <= is_last ? 9'h000 : (cur_remain - `BUS_BYTES);
      end
    end
  end

endmodule // user_msg_rx_deframer

`default_nettype wire

/* File: core/user_and_native_flow_control.v */
// transmit arbitration for user messages, native flow control and normal data
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctl_consts.vh"

// Overview of operation
// - take a message request next edge; wait while a message runs, unless final word.
// - message data ready within two cycles of a request unless pre-empted.
// - message ready rises one clock after request when nothing higher is pending.
// - message ready stays high while data of latest message is outstanding.
// - message ready drops while clock-comp, bonding or native flow request pends.
// - normal ready is low whenever message ready is high.
// - message word taken only on an edge with valid and ready both high.
// - final word uses only the leftmost bytes still needed.
// - valid low during message ready sends idle blocks in the message.
// - received message data comes with a valid flag.
// - each received message is a frame, last flag on its final word.
// - final received word sets the leftmost valid byte lanes on keep, only with last.
// - native flow ready pulses when the pending request is accepted.
// - pause count bits 8..15 stop partner data for count plus one cycles.
// - stop flag halts partner data until a non-stop message or reset.
// - zero pause with zero stop is resume; later requests are honoured.
// - completion mode has no effect in streaming configuration.
// - simplex builds keep only the message path of their direction.
// - normal data taken only on edges with valid and ready both high.
module user_and_native_flow_control #(
  parameter [1:0] BUILD = `BUILD_FULL_DUPLEX
) (
  input  wire        clock,
  input  wire        sys_rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // user message transmit
  input  wire        user_msg_tx_req,
  input  wire [7:0]  user_msg_tx_size,
  input  wire [0:63] user_msg_tx_data,
  input  wire        user_msg_tx_valid,
  output reg         user_msg_tx_ready,
  // normal transmit data
  input  wire [0:63] tx_data,
  input  wire        tx_valid,
  input  wire        tx_last,
  output reg         tx_ready,
  // native flow control transmit
  input  wire        nfc_tx_valid,
  input  wire [0:15] nfc_tx_data,
  output reg         nfc_tx_ready,
  // higher priority channel maintenance
  input  wire        clock_compensation_request,
  input  wire        channel_bonding_request,
  // outgoing channel blocks
  output reg  [2:0]  chan_tx_kind,
  output reg  [0:63] chan_tx_data,
  output reg  [7:0]  chan_tx_size,
  output reg  [3:0]  chan_tx_bytes,
  // incoming channel blocks
  input  wire [2:0]  chan_rx_kind,
  input  wire [0:63] chan_rx_data,
  input  wire [7:0]  chan_rx_size,
  // user message receive
  output wire [0:63] user_msg_rx_data,
  output wire        user_msg_rx_valid,
  output wire        user_msg_rx_last,
  output wire [0:7]  user_msg_rx_keep
);

  wire       tx_path_en;
  wire       rx_path_en;

  reg  [1:0] control;
  reg        msg_busy;
  reg  [8:0] msg_remain;
  reg        msg_first;
  reg  [7:0] msg_size;
  reg        stop_mode;
  reg  [8:0] pause_count;
  reg        in_frame;

  reg        next_busy;
  reg  [8:0] next_pause;
  reg        next_stop;
  reg        next_in_frame;
  reg        next_msg_ready;
  reg        next_tx_ready;

  // register read images
  reg [31:0] control_word;
  reg [31:0] status_word;

  wire       ufc_accept;
  wire       ufc_last;
  wire       normal_accept;
  wire       can_take;
  wire       msg_take;
  wire       prio_busy;
  wire       nfc_take;
  wire       nfc_pending;
  wire       higher_pending;
  wire       compl_eff;
  wire       next_hold;
  wire       rx_nfc;
  wire [7:0] rx_pause;
  wire       rx_stop;
  wire [3:0] last_bytes;
  wire       bus_hit;
  wire       resume_mode;
  wire       msg_final;
  wire       pausing;

  // bus decode
  wire       wb_write;
  wire       wb_read;
  wire       ctrl_write;

  // leftmost n byte lanes of a 64-bit word
  function [0:63] byte_mask;
    input [3:0] n;
    integer i;
    begin
      byte_mask = 64'h0000_0000_0000_0000;
      for (i = 0; i < 64; i = i + 1) begin
        byte_mask[i] = (n > (i / 8));
      end
    end
  endfunction

  // rx-only builds never send messages; tx-only builds never deliver them
  assign tx_path_en = (BUILD != `BUILD_SIMPLEX_RX);
  assign rx_path_en = (BUILD != `BUILD_SIMPLEX_TX);

  // handshakes sample the registered readies
  assign ufc_accept    = user_msg_tx_ready & user_msg_tx_valid;
  assign msg_final     = (msg_remain <= `BUS_BYTES);
  assign ufc_last      = ufc_accept & msg_final;
  assign normal_accept = tx_ready & tx_valid;

  // a new request waits unless the running message ends this edge
  assign can_take = ~msg_busy | ufc_last;
  assign msg_take = user_msg_tx_req & can_take & tx_path_en;

  // block slot order: committed accepts, then maintenance, then flow control
  assign prio_busy      = ufc_accept | normal_accept
                          | clock_compensation_request | channel_bonding_request;
  assign nfc_take       = nfc_tx_valid & ~nfc_tx_ready & ~prio_busy;
  assign nfc_pending    = nfc_tx_valid & ~nfc_tx_ready & ~nfc_take;
  assign higher_pending = clock_compensation_request | channel_bonding_request
                          | nfc_pending;

  assign compl_eff = control[`CTRL_COMPLETION_BIT] & ~control[`CTRL_STREAMING_BIT];

  // a transmit-only build has no receiver, so no pause can reach it
  assign rx_nfc      = rx_path_en & (chan_rx_kind == `KIND_NFC);
  assign rx_pause    = chan_rx_data[`NFC_PAUSE_MSB:`NFC_PAUSE_LSB];
  assign rx_stop     = chan_rx_data[`NFC_STOP_BIT];
  assign resume_mode = rx_nfc & ~rx_stop & (rx_pause == 8'h00);

  assign pausing    = (pause_count != `PAUSE_ZERO);
  assign last_bytes = msg_final ? msg_remain[3:0] : `BUS_BYTES_FULL;

  always @* begin
    next_busy = msg_take | (msg_busy & ~ufc_last);
  end

  // flow control received from the partner throttles our normal data
  always @* begin
    next_stop  = stop_mode;
    next_pause = pause_count;
    if (rx_nfc) begin
      if (rx_stop) begin
        next_stop  = 1'b1;
        next_pause = `PAUSE_ZERO;
      end else if (resume_mode) begin
        next_stop  = 1'b0;
        next_pause = `PAUSE_ZERO;
      end else begin
        next_stop  = 1'b0;
        next_pause = {1'b0, rx_pause} + `PAUSE_STEP;
      end
    end else if (pausing) begin
      next_pause = pause_count - `PAUSE_STEP;
    end
  end

  // streaming has no frames, so tlast is not tracked there
  always @* begin
    next_in_frame = in_frame;
    if (normal_accept & ~control[`CTRL_STREAMING_BIT]) begin
      next_in_frame = ~tx_last;
    end
  end

  // completion mode lets a started frame finish before honouring a hold
  assign next_hold = (next_stop | (next_pause != `PAUSE_ZERO))
                     & ~(compl_eff & next_in_frame);

  // both readies come from one decision, so they can never overlap
  always @* begin
    next_msg_ready = next_busy & ~higher_pending;
    next_tx_ready  = ~next_busy & ~higher_pending & ~next_hold & tx_path_en;
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      msg_busy          <= 1'b0;
      msg_remain        <= 9'h000;
      msg_first         <= 1'b0;
      msg_size          <= 8'h00;
      user_msg_tx_ready <= 1'b0;
      tx_ready          <= 1'b0;
      nfc_tx_ready      <= 1'b0;
      stop_mode         <= 1'b0;
      pause_count       <= `PAUSE_ZERO;
      in_frame          <= 1'b0;
    end else begin
      msg_busy    <= next_busy;
      stop_mode   <= next_stop;
      pause_count <= next_pause;
      in_frame    <= next_in_frame;
      if (msg_take) begin
        msg_remain <= {1'b0, user_msg_tx_size} + `MSG_SIZE_ONE;
        msg_size   <= user_msg_tx_size;
        msg_first  <= 1'b1;
      end else if (ufc_accept) begin
        msg_remain <= ufc_last ? 9'h000 : (msg_remain - `BUS_BYTES);
        msg_first  <= 1'b0;
      end
      // ready one clock after the request, held until all bytes taken
      user_msg_tx_ready <= next_msg_ready;
      // normal path comes back once the message is done
      tx_ready <= next_tx_ready;
      // single-cycle accept; valid is held by the application until then
      nfc_tx_ready <= nfc_take;
    end
  end

  // outgoing block selection
  always @(posedge clock) begin
    if (sys_rst) begin
      chan_tx_kind  <= `KIND_IDLE;
      chan_tx_data  <= 64'h0000_0000_0000_0000;
      chan_tx_size  <= 8'h00;
      chan_tx_bytes <= 4'h0;
    end else begin
      chan_tx_size  <= msg_size;
      chan_tx_bytes <= 4'h0;
      chan_tx_data  <= 64'h0000_0000_0000_0000;
      if (ufc_accept) begin
        chan_tx_kind  <= msg_first ? `KIND_MSG_START : `KIND_MSG_DATA;
        chan_tx_bytes <= last_bytes;
        chan_tx_data  <= user_msg_tx_data & byte_mask(last_bytes);
      end else if (normal_accept) begin
        chan_tx_kind <= `KIND_DATA;
        chan_tx_data <= tx_data;
      end else if (clock_compensation_request) begin
        chan_tx_kind <= `KIND_CLK_COMP;
      end else if (channel_bonding_request) begin
        chan_tx_kind <= `KIND_CH_BOND;
      end else if (nfc_take) begin
        chan_tx_kind       <= `KIND_NFC;
        chan_tx_data[0:15] <= nfc_tx_data;
      end else begin
        // also covers valid low while message ready is high
        chan_tx_kind <= `KIND_IDLE;
      end
    end
  end

  // wishbone slave: one wait state, ack for one cycle
  assign bus_hit    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_write   = bus_hit & wb_we_i;
  assign wb_read    = bus_hit & ~wb_we_i;
  // only byte lane 0 carries control bits
  assign ctrl_write = wb_write & wb_sel_i[0] & (wb_adr_i == `REG_CONTROL_ADDR);

  // register images built from their field positions
  always @* begin
    control_word                       = 32'h0000_0000;
    control_word[`CTRL_STREAMING_BIT]  = control[`CTRL_STREAMING_BIT];
    control_word[`CTRL_COMPLETION_BIT] = control[`CTRL_COMPLETION_BIT];
    status_word                        = 32'h0000_0000;
    status_word[`STAT_STOP_BIT]        = stop_mode;
    status_word[`STAT_PAUSE_BIT]       = pausing;
    status_word[`STAT_MSG_BUSY_BIT]    = msg_busy;
    status_word[`STAT_COMPL_EFF_BIT]   = compl_eff;
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      control  <= `CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_hit;
      wb_dat_o <= 32'h0000_0000;
      if (ctrl_write) begin
        control[`CTRL_STREAMING_BIT]  <= wb_dat_i[`CTRL_STREAMING_BIT];
        control[`CTRL_COMPLETION_BIT] <= wb_dat_i[`CTRL_COMPLETION_BIT];
      end
      if (wb_read) begin
        case (wb_adr_i)
          `REG_CONTROL_ADDR: begin
            wb_dat_o <= control_word;
          end
          `REG_STATUS_ADDR: begin
            wb_dat_o <= status_word;
          end
          `REG_PAUSE_ADDR: begin
            wb_dat_o <= {23'h00_0000, pause_count};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  user_msg_rx_deframer u_rx_deframer (
    .clock             (clock),
    .sys_rst           (sys_rst),
    .enable            (rx_path_en),
    .chan_rx_kind      (chan_rx_kind),
    .chan_rx_data      (chan_rx_data),
    .chan_rx_size      (chan_rx_size),
    .user_msg_rx_data  (user_msg_rx_data),
    .user_msg_rx_valid (user_msg_rx_valid),
    .user_msg_rx_last  (user_msg_rx_last),
    .user_msg_rx_keep  (user_msg_rx_keep)
  );

endmodule // user_and_native_flow_control

`default_nettype wire

/* File: sim/flow_ctl_assertions.sv */
// concurrent checks on the flow control block ports
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctl_consts.vh"
module flow_ctl_assertions (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        user_msg_tx_req,
  input wire logic        user_msg_tx_valid,
  input wire logic        user_msg_tx_ready,
  input wire logic [0:63] tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        nfc_tx_valid,
  input wire logic [0:15] nfc_tx_data,
  input wire logic        nfc_tx_ready,
  input wire logic        clock_compensation_request,
  input wire logic        channel_bonding_request,
  input wire logic [2:0]  chan_tx_kind,
  input wire logic [0:63] chan_tx_data,
  input wire logic        user_msg_rx_valid,
  input wire logic        user_msg_rx_last,
  input wire logic [0:7]  user_msg_rx_keep
);
  wire pre = clock_compensation_request || channel_bonding_request;
  wire beat = tx_ready && tx_valid;
  wire mbeat = user_msg_tx_ready && user_msg_tx_valid;
  default clocking dclk @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_wb_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_msg_ask; $rose(user_msg_tx_req) && !user_msg_tx_ready; endsequence
  a_wb_answer: assert property (s_wb_take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  a_ready_next: assert property (
    s_msg_ask ##0 !(pre || nfc_tx_valid) |=> user_msg_tx_ready)
    else $error("message ready late");
  a_ready_soon: assert property (
    s_msg_ask |-> ##[1:2] (user_msg_tx_ready || pre || nfc_tx_valid))
    else $error("message ready not within two");
  a_ready_excl: assert property (user_msg_tx_ready |-> !tx_ready)
    else $error("both readies high");
  a_preempt_drop: assert property (pre |=> !user_msg_tx_ready)
    else $error("message ready during maintenance");
  a_msg_beat: assert property (
    mbeat |=> chan_tx_kind inside {`KIND_MSG_START, `KIND_MSG_DATA})
    else $error("message word lost");
  a_idle_gap: assert property (
    user_msg_tx_ready && !user_msg_tx_valid && !nfc_tx_valid && !pre |=>
    chan_tx_kind == `KIND_IDLE) else $error("no idle in message gap");
  a_normal_beat: assert property (
    beat |=> chan_tx_kind == `KIND_DATA && chan_tx_data == $past(tx_data))
    else $error("normal word lost");
  a_no_beat: assert property (
    !beat && !mbeat |=> !(chan_tx_kind inside {`KIND_DATA, `KIND_MSG_START, `KIND_MSG_DATA}))
    else $error("word sent without handshake");
  a_nfc_answer: assert property (
    nfc_tx_ready |-> chan_tx_kind == `KIND_NFC && chan_tx_data[0:15] == $past(nfc_tx_data)
    ##1 !nfc_tx_ready) else $error("flow ack wrong");
  a_rx_keep: assert property (
    user_msg_rx_keep != 8'h00 |-> user_msg_rx_last && user_msg_rx_valid)
    else $error("keep outside last word");
endmodule // flow_ctl_assertions
bind user_and_native_flow_control flow_ctl_assertions chk (
  .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .user_msg_tx_req(user_msg_tx_req),
  .user_msg_tx_valid(user_msg_tx_valid), .user_msg_tx_ready(user_msg_tx_ready),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .nfc_tx_valid(nfc_tx_valid),
  .nfc_tx_data(nfc_tx_data), .nfc_tx_ready(nfc_tx_ready),
  .clock_compensation_request(clock_compensation_request),
  .channel_bonding_request(channel_bonding_request), .chan_tx_kind(chan_tx_kind),
  .chan_tx_data(chan_tx_data), .user_msg_rx_valid(user_msg_rx_valid),
  .user_msg_rx_last(user_msg_rx_last), .user_msg_rx_keep(user_msg_rx_keep));
`default_nettype wire

/* File: sim/user_app_source.sv */
// normal data source standing in for the user application
`timescale 1ns/1ps
`default_nettype none
module user_app_source (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        tx_ready,
  output var  logic [0:63] tx_data,
  output var  logic        tx_valid,
  output var  logic        tx_last,
  output var  logic [7:0]  beats
);
  // word held until taken; every fourth beat it idles a cycle to look slow
  always @(posedge clock) begin
    if (sys_rst) begin
      {tx_valid, tx_last, beats} <= 10'h000;
      tx_data <= 64'h0000_0000_0000_0000;
    end else if (tx_valid && tx_ready) begin
      beats    <= beats + 8'h01;
      tx_valid <= beats[1:0] != 2'h3;
      tx_last  <= beats[2:0] == 3'h6;
      tx_data  <= ~tx_data;
    end else if (!tx_valid) begin
      tx_valid <= 1'b1;
      tx_data  <= {8{beats}};
    end
  end
endmodule // user_app_source
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the flow control block
`timescale 1ns/1ps
`default_nettype none
`include "flow_ctl_consts.vh"
module tb_top;
  typedef struct packed {logic [7:0] sz; logic [1:0] mode; logic [5:0] words;
                         logic [3:0] lastb;} row_t;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_valid, tx_last, tx_ready;
  logic        user_msg_tx_req, user_msg_tx_valid, user_msg_tx_ready, nfc_tx_valid;
  logic        nfc_tx_ready, user_msg_rx_valid, user_msg_rx_last;
  logic        clock_compensation_request, channel_bonding_request;
  logic [3:0]  wb_sel_i, chan_tx_bytes;
  logic [7:0]  wb_adr_i, user_msg_tx_size, chan_rx_size, chan_tx_size, beats;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [0:63] user_msg_tx_data, chan_rx_data, tx_data, chan_tx_data, user_msg_rx_data;
  logic [0:15] nfc_tx_data;
  logic [2:0]  chan_rx_kind, chan_tx_kind;
  logic [0:7]  user_msg_rx_keep;
  int          checked = 0;
  int          miscompares = 0;
  integer      n;
  // modes: 0 plain, 1 idle gap, 2 clock comp, 3 bonding while waiting
  row_t rows [6] = '{'{8'h00, 2'h0, 6'h01, 4'h1}, '{8'h07, 2'h2, 6'h01, 4'h8},
                     '{8'h08, 2'h1, 6'h02, 4'h1}, '{8'h0b, 2'h3, 6'h02, 4'h4},
                     '{8'hfe, 2'h0, 6'h20, 4'h7}, '{8'hff, 2'h1, 6'h20, 4'h8}};
  always #10 clock = ~clock;
  user_and_native_flow_control dut (.clock(clock), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .user_msg_tx_req(user_msg_tx_req), .user_msg_tx_size(user_msg_tx_size),
    .user_msg_tx_data(user_msg_tx_data), .user_msg_tx_valid(user_msg_tx_valid),
    .user_msg_tx_ready(user_msg_tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .nfc_tx_valid(nfc_tx_valid),
    .nfc_tx_data(nfc_tx_data), .nfc_tx_ready(nfc_tx_ready),
    .clock_compensation_request(clock_compensation_request),
    .channel_bonding_request(channel_bonding_request), .chan_tx_kind(chan_tx_kind),
    .chan_tx_data(chan_tx_data), .chan_tx_size(chan_tx_size), .chan_tx_bytes(chan_tx_bytes),
    .chan_rx_kind(chan_rx_kind), .chan_rx_data(chan_rx_data), .chan_rx_size(chan_rx_size),
    .user_msg_rx_data(user_msg_rx_data), .user_msg_rx_valid(user_msg_rx_valid),
    .user_msg_rx_last(user_msg_rx_last), .user_msg_rx_keep(user_msg_rx_keep));
  user_app_source src (.clock(clock), .sys_rst(sys_rst), .tx_ready(tx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .beats(beats));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    integer t;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'h3, we, 4'hf, a, d};
    for (t = 0; t < 50 && wb_ack_o !== 1'b1; t++) @(posedge clock);
    chk("wb ack", 1'b1, wb_ack_o);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic send_msg(input row_t r);
    integer k;
    integer t;
    integer b;
    @(posedge clock);
    {user_msg_tx_req, user_msg_tx_size} <= {1'b1, r.sz};
    clock_compensation_request <= r.mode == 2'h2;
    channel_bonding_request <= r.mode == 2'h3;
    @(posedge clock);
    user_msg_tx_req <= 1'b0;
    @(negedge clock);
    chk("msg ready", r.mode < 2'h2, user_msg_tx_ready);
    chk("normal ready", 1'b0, tx_ready);
    @(posedge clock);
    {clock_compensation_request, channel_bonding_request} <= 2'h0;
    for (t = 0; t < 6 && user_msg_tx_ready !== 1'b1; t++) @(negedge clock);
    chk("msg ready held", 1'b1, user_msg_tx_ready);
    @(posedge clock);
    {user_msg_tx_valid, user_msg_tx_data} <= {1'b1, {64{1'b1}}};
    for (k = 0; k < r.words; k++) begin
      if (k == 1 && r.mode == 2'h1) begin
        @(posedge clock);
        {user_msg_tx_valid, user_msg_tx_data} <= {1'b1, {64{1'b1}}};
        @(negedge clock);
        chk("gap kind", `KIND_IDLE, chan_tx_kind);
      end
      @(posedge clock);
      if (k == r.words - 1 || (k == 0 && r.mode == 2'h1))
        {user_msg_tx_valid, user_msg_tx_data} <= 65'h0;
      @(negedge clock);
      b = (k == r.words - 1) ? r.lastb : 8;
      chk("msg kind", k ? `KIND_MSG_DATA : `KIND_MSG_START, chan_tx_kind);
      chk("msg bytes", b, chan_tx_bytes);
      chk("msg size", r.sz, chan_tx_size);
      chk("msg data", {64{1'b1}} << (64 - 8 * b), chan_tx_data);
    end
    chk("ready after", 2'h1, {user_msg_tx_ready, tx_ready});
  endtask
  task automatic nfc_send(input logic [0:15] w);
    integer t;
    @(posedge clock);
    {nfc_tx_valid, nfc_tx_data} <= {1'b1, w};
    for (t = 0; t < 20 && nfc_tx_ready !== 1'b1; t++) @(negedge clock);
    chk("nfc kind", `KIND_NFC, chan_tx_kind);
    chk("nfc word", w, chan_tx_data[0:15]);
    @(posedge clock);
    {nfc_tx_valid, nfc_tx_data} <= {1'b0, ~w};
  endtask
  task automatic rx_block(input logic [2:0] kind, input logic [0:63] d);
    @(posedge clock);
    {chan_rx_kind, chan_rx_data, chan_rx_size} <= {kind, d, 8'h0b};
    @(posedge clock);
    {chan_rx_kind, chan_rx_data} <= {`KIND_IDLE, ~d};
    @(negedge clock);
  endtask
  task automatic ready_span(input integer cycles);
    n = 0;
    repeat (cycles) begin
      if (tx_ready === 1'b0) n++;
      @(negedge clock);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} = 47'h0;
    {user_msg_tx_req, user_msg_tx_size, user_msg_tx_valid, user_msg_tx_data} = 74'h0;
    {nfc_tx_valid, nfc_tx_data, clock_compensation_request, channel_bonding_request} = 19'h0;
    {chan_rx_kind, chan_rx_data, chan_rx_size} = 75'h0;
    repeat (9) @(posedge clock);
    @(negedge clock);
    chk("reset outs", 4'h0, {user_msg_tx_ready, tx_ready, nfc_tx_ready, wb_ack_o});
    @(posedge clock);
    sys_rst <= 1'b0;
    wb_xfer(1'b1, `REG_CONTROL_ADDR, 32'h0000_0002, q);
    wb_xfer(1'b0, `REG_STATUS_ADDR, 32'h0000_0000, q);
    chk("completion on", 1'b1, q[`STAT_COMPL_EFF_BIT]);
    wb_xfer(1'b1, `REG_CONTROL_ADDR, 32'h0000_0003, q);
    wb_xfer(1'b0, `REG_CONTROL_ADDR, 32'h0000_0000, q);
    chk("control back", 32'h0000_0003, q);
    wb_xfer(1'b0, `REG_STATUS_ADDR, 32'h0000_0000, q);
    chk("completion streaming", 1'b0, q[`STAT_COMPL_EFF_BIT]);
    wb_xfer(1'b0, 8'h40, 32'h0000_0000, q);
    chk("unmapped read", 32'h0000_0000, q);
    wb_xfer(1'b1, `REG_CONTROL_ADDR, 32'h0000_0000, q);
    foreach (rows[i]) send_msg(rows[i]);
    nfc_send(16'h0100);
    nfc_send(16'h0005);
    nfc_send(16'h0000);
    rx_block(`KIND_MSG_START, 64'h0123_4567_89ab_cdef);
    chk("rx flags", 2'h2, {user_msg_rx_valid, user_msg_rx_last});
    chk("rx data", 64'h0123_4567_89ab_cdef, user_msg_rx_data);
    rx_block(`KIND_MSG_DATA, 64'hfedc_ba98_7654_3210);
    chk("rx last", 10'h3f0, {user_msg_rx_valid, user_msg_rx_last, user_msg_rx_keep});
    @(negedge clock);
    chk("rx idle", 1'b0, user_msg_rx_valid);
    rx_block(`KIND_NFC, {16'h0100, 48'h0});
    ready_span(8);
    chk("stop span", 8, n);
    wb_xfer(1'b0, `REG_STATUS_ADDR, 32'h0000_0000, q);
    chk("stop flag", 1'b1, q[`STAT_STOP_BIT]);
    rx_block(`KIND_NFC, 64'h0);
    repeat (4) @(negedge clock);
    chk("resumed", 1'b1, tx_ready);
    rx_block(`KIND_NFC, {16'h0003, 48'h0});
    ready_span(12);
    chk("pause span", 4, n);
    rx_block(`KIND_NFC, {16'h0100, 48'h0});
    chk("stopped again", 1'b0, tx_ready);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(negedge clock);
    chk("reset resumes", 1'b1, tx_ready);
    wb_xfer(1'b0, `REG_STATUS_ADDR, 32'h0000_0000, q);
    chk("reset stop flag", 1'b0, q[`STAT_STOP_BIT]);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
